/* File: core/cfe_top.sv */
// ccd front end digital control: serial settings port, apb view and
// the 10-bit converter output port on the conversion clock.
// assumes an apb master on clk and a converter core on conversionClock.
`timescale 1ns/100ps
`include "cfe_params.svh"

module cfe_top
  import cfe_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serialClock,
  input wire logic serialDataIn,
  input wire logic standbyN,
  input wire logic blankN,
  input wire logic converterClampN,
  input wire logic clampLevelAdjustOpen,
  input wire logic conversionClock,
  input wire logic [`CFE_CODE_W-1:0] analogCode,
  output logic [`CFE_CODE_W-1:0] sampleOut,
  output logic sampleOe,
  output logic [`CFE_GAIN_W-1:0] gainCode,
  output logic [`CFE_RANGE_W-1:0] gainRangeSelect,
  output logic [`CFE_OFFSET_W-1:0] blankOffset
);

  // bit positions in the conversion-domain synchroniser
  localparam int S_RUN = 0;
  localparam int S_BLANK = 1;
  localparam int S_CLAMP = 2;
  localparam int S_OPEN = 3;
  localparam int S_REQ = 4;

  logic [1:0] stbyS_q;
  logic running;
  logic [`CFE_WORD_W-1:0] shiftWord;
  logic storePulse;
  logic [`CFE_SEL_W-1:0] storeSel;
  logic [`CFE_DATA_W-1:0] storeData;
  cfe_settings_t settings_q;
  logic [`CFE_CODE_W-1:0] clampCode_q;
  cfe_reg_t setupReg;
  logic [31:0] readWord;
  logic [31:0] prdata_q;
  logic pslverr_q;
  cfe_link_t liveWord;
  cfe_link_t heldWord_q;
  logic reqT_q;
  logic [1:0] ackS_q;
  logic [1:0] rstC_q;
  logic rstConv;
  logic [4:0] cSync1_q;
  logic [4:0] cSync2_q;
  logic ackT_q;
  cfe_link_t linkWord_q;
  logic [`CFE_CODE_W-1:0] clampLevel;
  logic [`CFE_CODE_W-1:0] convCode_q;
  logic [`CFE_CODE_W-1:0] sampleOut_q;
  logic sampleOe_q;

  // word-aligned apb decode, shared by read and write
  function automatic cfe_reg_t decodeReg(input logic [ADDR_W-1:0] a);
    cfe_reg_t r;
    r = CFE_R_NONE;
    if (a == ADDR_W'(`CFE_ADDR_CLAMP)) begin
      r = CFE_R_CLAMP;
    end else if (a == ADDR_W'(`CFE_ADDR_SET)) begin
      r = CFE_R_SET;
    end else if (a == ADDR_W'(`CFE_ADDR_SHIFT)) begin
      r = CFE_R_SHIFT;
    end
    return r;
  endfunction

  // ---- control clock domain ----

  // standby pin enters through two flip-flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stbyS_q <= 2'h0;
    end else begin
      stbyS_q <= {stbyS_q[0], standbyN};
    end
  end

  assign running = stbyS_q[1];

  cfe_serial_rx #(
    .WORD_W(`CFE_WORD_W)
  ) u_serial (
    .clk(clk),
    .rst(rst),
    .serialClock(serialClock),
    .serialDataIn(serialDataIn),
    .runEn(running),
    .shiftWord(shiftWord),
    .storePulse(storePulse)
  );

  assign storeSel = shiftWord[`CFE_SEL_LSB +: `CFE_SEL_W];
  assign storeData = shiftWord[`CFE_DATA_LSB +: `CFE_DATA_W];

  // only a store touches the settings; narrow fields keep low bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settings_q.gain <= `CFE_GAIN_RST;
      settings_q.range <= `CFE_RANGE_RST;
      settings_q.offset <= `CFE_OFFSET_RST;
    end else if (storePulse) begin
      case (storeSel)
        `CFE_SEL_GAIN: begin
          settings_q.gain <= storeData;
        end
        `CFE_SEL_RANGE: begin
          settings_q.range <= storeData[`CFE_RANGE_W-1:0];
        end
        `CFE_SEL_OFFSET: begin
          settings_q.offset <= storeData[`CFE_OFFSET_W-1:0];
        end
        default: begin
          settings_q <= settings_q; // fourth slot has no register
        end
      endcase
    end
  end

  // settings drive the gain and offset converters directly
  assign gainCode = settings_q.gain;
  assign gainRangeSelect = settings_q.range;
  assign blankOffset = settings_q.offset;

  // apb: zero wait states, read data latched in the setup cycle
  assign pready = 1'h1;
  assign setupReg = decodeReg(paddr);

  always_comb begin
    readWord = 32'h0000_0000;
    case (setupReg)
      CFE_R_CLAMP: begin
        readWord[`CFE_CODE_W-1:0] = clampCode_q;
      end
      CFE_R_SET: begin
        readWord[`CFE_SET_GAIN_LSB +: `CFE_GAIN_W] = settings_q.gain;
        readWord[`CFE_SET_RANGE_LSB +: `CFE_RANGE_W] = settings_q.range;
        readWord[`CFE_SET_OFFSET_LSB +: `CFE_OFFSET_W] = settings_q.offset;
      end
      CFE_R_SHIFT: begin
        readWord[`CFE_WORD_W-1:0] = shiftWord;
        readWord[`CFE_SHIFT_RUN_BIT] = running;
      end
      default: begin
        readWord = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'h0;
    end else if (psel && !penable) begin
      prdata_q <= pwrite ? 32'h0000_0000 : readWord;
      pslverr_q <= (setupReg == CFE_R_NONE);
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // clamp code used when the adjust pin is driven, not left open
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clampCode_q <= `CFE_CLAMP_RST;
    end else if (psel && penable && pwrite && setupReg == CFE_R_CLAMP) begin
      clampCode_q <= pwdata[`CFE_CODE_W-1:0];
    end
  end

  // request toggle; the held word stays put until the far side acks
  assign liveWord = '{offset: settings_q.offset, clampCode: clampCode_q};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      heldWord_q <= '{offset: `CFE_OFFSET_RST, clampCode: `CFE_CLAMP_RST};
      reqT_q <= 1'h0;
    end else if (reqT_q == ackS_q[1] && liveWord != heldWord_q) begin
      heldWord_q <= liveWord;
      reqT_q <= ~reqT_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ackS_q <= 2'h0;
    end else begin
      ackS_q <= {ackS_q[0], ackT_q};
    end
  end

  // ---- conversion clock domain ----

  // reset asserts at once, releases on the conversion clock
  always_ff @(posedge conversionClock or posedge rst) begin
    if (rst) begin
      rstC_q <= 2'h3;
    end else begin
      rstC_q <= {rstC_q[0], 1'h0};
    end
  end

  assign rstConv = rstC_q[1];

  // pins and request toggle pass two flip-flops
  always_ff @(posedge conversionClock or posedge rstConv) begin
    if (rstConv) begin
      cSync1_q <= 5'h06;
      cSync2_q <= 5'h06;
    end else begin
      cSync1_q <= {reqT_q, clampLevelAdjustOpen, converterClampN,
                   blankN, standbyN};
      cSync2_q <= cSync1_q;
    end
  end

  // take the held word once per request, then acknowledge
  always_ff @(posedge conversionClock or posedge rstConv) begin
    if (rstConv) begin
      linkWord_q <= '{offset: `CFE_OFFSET_RST, clampCode: `CFE_CLAMP_RST};
      ackT_q <= 1'h0;
    end else if (cSync2_q[S_REQ] != ackT_q) begin
      linkWord_q <= heldWord_q;
      ackT_q <= cSync2_q[S_REQ];
    end
  end

  assign clampLevel = cSync2_q[S_OPEN] ? `CFE_CLAMP_OPEN_CODE
                                       : linkWord_q.clampCode;

  // conversion on the rising edge; clamp wins over blanking since it
  // sits in front of the converter
  always_ff @(posedge conversionClock or posedge rstConv) begin
    if (rstConv) begin
      convCode_q <= '0;
    end else if (cSync2_q[S_RUN]) begin
      if (!cSync2_q[S_CLAMP]) begin
        convCode_q <= clampLevel;
      end else if (!cSync2_q[S_BLANK]) begin
        convCode_q <= cfe_blank_code(clampLevel, linkWord_q.offset);
      end else begin
        convCode_q <= analogCode;
      end
    end
  end

  // outputs change on the falling edge, half a period after conversion
  always_ff @(negedge conversionClock or posedge rstConv) begin
    if (rstConv) begin
      sampleOut_q <= '0;
      sampleOe_q <= 1'h0;
    end else begin
      if (cSync2_q[S_RUN]) begin
        sampleOut_q <= convCode_q;
      end
      sampleOe_q <= cSync2_q[S_RUN];
    end
  end

  assign sampleOut = sampleOut_q;
  assign sampleOe = sampleOe_q;

  // ---- checks, control domain ----

  a_gain_store: assert property (
    @(posedge clk) disable iff (rst)
    storePulse && storeSel == `CFE_SEL_GAIN |=>
      gainCode == $past(storeData))
    else $error("gain code not stored");

  a_offset_store: assert property (
    @(posedge clk) disable iff (rst)
    storePulse && storeSel == `CFE_SEL_OFFSET |=>
      blankOffset == $past(storeData[`CFE_OFFSET_W-1:0])
      && $stable(gainCode))
    else $error("offset not stored");

  a_settings_hold: assert property (
    @(posedge clk) disable iff (rst)
    !storePulse |=> $stable(settings_q))
    else $error("settings changed without store");

  a_standby_quiet: assert property (
    @(posedge clk) disable iff (rst)
    !running |-> !storePulse ##1 $stable(shiftWord))
    else $error("store or shift during standby");

  // ---- checks, conversion domain ----

  sequence s_run2;
    cSync2_q[S_RUN] [*2];
  endsequence

  a_clamp_level: assert property (
    @(posedge conversionClock) disable iff (rstConv)
    cSync2_q[S_RUN] && !cSync2_q[S_CLAMP] |=>
      convCode_q == $past(clampLevel)
      && (!$past(cSync2_q[S_OPEN]) || convCode_q == `CFE_CLAMP_OPEN_CODE))
    else $error("clamp code not applied");

  a_blank_level: assert property (
    @(posedge conversionClock) disable iff (rstConv)
    cSync2_q[S_RUN] && cSync2_q[S_CLAMP] && !cSync2_q[S_BLANK] |=>
      convCode_q == cfe_blank_code($past(clampLevel),
                                   $past(linkWord_q.offset)))
    else $error("blanking level wrong");

  a_output_fall: assert property (
    @(posedge conversionClock) disable iff (rstConv)
    s_run2 ##1 cSync2_q[S_RUN] |-> sampleOut == convCode_q && sampleOe)
    else $error("sample not driven on falling edge");

  a_standby_float: assert property (
    @(posedge conversionClock) disable iff (rstConv)
    !cSync2_q[S_RUN] [*2] |-> !sampleOe && $stable(convCode_q))
    else $error("outputs not floated in standby");

endmodule

/* File: common/cfe_params.svh */
// constants of the ccd front end control block: offsets, fields, resets.
// assumes it is included by the package and by the design files.
`ifndef CFE_PARAMS_SVH
`define CFE_PARAMS_SVH

// serial word layout: data above, select bits at the bottom
`define CFE_WORD_W 10
`define CFE_SEL_LSB 0
`define CFE_SEL_W 2
`define CFE_DATA_LSB 2
`define CFE_DATA_W 8
`define CFE_SEL_GAIN 2'h0
`define CFE_SEL_RANGE 2'h1
`define CFE_SEL_OFFSET 2'h2

// setting widths and reset values
`define CFE_GAIN_W 8
`define CFE_RANGE_W 3
`define CFE_OFFSET_W 6
`define CFE_CODE_W 10
`define CFE_GAIN_RST 8'h00
`define CFE_RANGE_RST 3'h0
`define CFE_OFFSET_RST 6'h00
`define CFE_CLAMP_OPEN_CODE 10'h03E
`define CFE_CLAMP_RST 10'h03E

// apb byte offsets
`define CFE_ADDR_CLAMP 12'h000
`define CFE_ADDR_SET 12'h004
`define CFE_ADDR_SHIFT 12'h008

// field positions inside the read words
`define CFE_SET_GAIN_LSB 0
`define CFE_SET_RANGE_LSB 8
`define CFE_SET_OFFSET_LSB 16
`define CFE_SHIFT_RUN_BIT 16

`endif

/* File: common/cfe_pkg.sv */
// types shared by the ccd front end control design.
// assumes cfe_params.svh is on the include path.
`include "cfe_params.svh"

package cfe_pkg;

  // settings written through the serial port
  typedef struct packed {
    logic [`CFE_GAIN_W-1:0] gain;
    logic [`CFE_RANGE_W-1:0] range;
    logic [`CFE_OFFSET_W-1:0] offset;
  } cfe_settings_t;

  // word handed to the conversion clock domain
  typedef struct packed {
    logic [`CFE_OFFSET_W-1:0] offset;
    logic [`CFE_CODE_W-1:0] clampCode;
  } cfe_link_t;

  typedef enum logic [1:0] {
    CFE_R_CLAMP,
    CFE_R_SET,
    CFE_R_SHIFT,
    CFE_R_NONE
  } cfe_reg_t;

  // black level plus offset, saturated so the code never wraps
  function automatic logic [`CFE_CODE_W-1:0] cfe_blank_code(
    input logic [`CFE_CODE_W-1:0] black,
    input logic [`CFE_OFFSET_W-1:0] ofs
  );
    logic [`CFE_CODE_W:0] sum;
    sum = {1'h0, black} + {5'h00, ofs};
    return sum[`CFE_CODE_W] ? '1 : sum[`CFE_CODE_W-1:0];
  endfunction

endpackage

/* File: core/cfe_serial_rx.sv */
// two-wire write-only serial receiver: shift on clock rise, store on
// a data fall that follows a clock fall with data high.
// assumes pins come straight from outside; both pass two flip-flops here.
`timescale 1ns/100ps
`include "cfe_params.svh"

module cfe_serial_rx
  import cfe_pkg::*;
#(
  parameter int WORD_W = `CFE_WORD_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic serialClock,
  input wire logic serialDataIn,
  input wire logic runEn,
  output logic [WORD_W-1:0] shiftWord,
  output logic storePulse
);

  logic [1:0] clkSync_q;
  logic [1:0] dataSync_q;
  logic clkPrev_q;
  logic dataPrev_q;
  logic armed_q;
  logic clkRise;
  logic clkFall;
  logic dataFall;

  // both pins share the same delay so their order is kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkSync_q <= 2'h0;
      dataSync_q <= 2'h0;
      clkPrev_q <= 1'h0;
      dataPrev_q <= 1'h0;
    end else begin
      clkSync_q <= {clkSync_q[0], serialClock};
      dataSync_q <= {dataSync_q[0], serialDataIn};
      clkPrev_q <= clkSync_q[1];
      dataPrev_q <= dataSync_q[1];
    end
  end

  assign clkRise = clkSync_q[1] & ~clkPrev_q;
  assign clkFall = ~clkSync_q[1] & clkPrev_q;
  assign dataFall = ~dataSync_q[1] & dataPrev_q;

  // shift register, frozen in standby
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shiftWord <= '0;
    end else if (runEn && clkRise) begin
      shiftWord <= {shiftWord[WORD_W-2:0], dataSync_q[1]};
    end
  end

  // arm when data is high at a clock fall; a rise or store disarms
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'h0;
    end else if (!runEn || clkRise || storePulse) begin
      armed_q <= 1'h0;
    end else if (clkFall) begin
      armed_q <= dataSync_q[1];
    end
  end

  assign storePulse = armed_q & dataFall & runEn;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_shift_on_rise: assert property (
    runEn && clkRise |=>
      shiftWord == {$past(shiftWord[WORD_W-2:0]), $past(dataSync_q[1])})
    else $error("serial bit not shifted on clock rise");

  sequence s_arm_low;
    clkFall && !dataSync_q[1] ##1 !clkRise [*2];
  endsequence

  a_low_no_store: assert property (
    s_arm_low |-> !storePulse && !$past(storePulse))
    else $error("store taken without data high at clock fall");

  a_store_on_fall: assert property (
    storePulse |-> $past(dataSync_q[1]) && !dataSync_q[1] && runEn)
    else $error("store not on a data falling edge");

endmodule

/* File: verif/cfe_ctrl_model.sv */
// camera controller model: sends one serial settings word on request.
// assumes go is a one-clk pulse on clk and word is held until busy falls.
`timescale 1ns/100ps

module cfe_ctrl_model #(
  parameter int QUARTER = 17
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [9:0] word,
  output logic serialClock,
  output logic serialDataIn,
  output logic busy
);
  // quarter of 17 clk gives a 3.4 us serial period, just under 300 kHz
  task automatic hold();
    repeat (QUARTER) @(posedge clk);
  endtask

  // msb first; data is dropped before every clock fall except the last
  initial begin
    serialClock = 1'b0;
    serialDataIn = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 9; i >= 0; i--) begin
          serialDataIn <= word[i];
          hold();
          serialClock <= 1'b1;
          hold();
          serialDataIn <= (i == 0);
          hold();
          serialClock <= 1'b0;
          hold();
        end
        serialDataIn <= 1'b0;
        hold();
        busy <= 1'b0;
      end
    end
  end
endmodule

/* File: verif/tb_top.sv */
// self-checking bench: apb access, serial stores, conversion port.
// assumes cfe_top with zero-wait apb and the controller model beside it.
`timescale 1ns/100ps

module tb_top;
  import cfe_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic serialClock, serialDataIn, standbyN, blankN, converterClampN;
  logic adjOpen, conversionClock, go, busy, sampleOe;
  logic [9:0] analogCode, sampleOut, word;
  logic [7:0] gainCode;
  logic [2:0] gainRangeSelect;
  logic [5:0] blankOffset;
  logic [9:0] codes [3] = '{10'h000, 10'h3FF, 10'h2A5};
  int n_fail, n_checks, cyc;

  cfe_top cfe_top_i (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serialClock(serialClock),
    .serialDataIn(serialDataIn), .standbyN(standbyN), .blankN(blankN),
    .converterClampN(converterClampN), .clampLevelAdjustOpen(adjOpen),
    .conversionClock(conversionClock), .analogCode(analogCode),
    .sampleOut(sampleOut), .sampleOe(sampleOe), .gainCode(gainCode),
    .gainRangeSelect(gainRangeSelect), .blankOffset(blankOffset));

  cfe_ctrl_model cfe_ctrl_model_i (.clk(clk), .go(go), .word(word),
    .serialClock(serialClock), .serialDataIn(serialDataIn), .busy(busy));

  // control clock 50 ns; conversion clock 64 ns with an odd phase
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    conversionClock = 1'b0;
    #3.3;
    forever #32 conversionClock = ~conversionClock;
  end

  task automatic report_and_stop();
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; an idle edge follows so the next setup is clean
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; only the bench timeout ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // serial store, then time for sync and the crossing to settle
  task automatic send(input logic [9:0] w);
    word <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    while (busy === 1'b1) begin
      @(posedge clk);
    end
    repeat (20) @(posedge clk);
  endtask

  task automatic conv(input int n);
    repeat (n) @(posedge conversionClock);
    @(posedge clk);
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    standbyN = 1'b0;
    blankN = 1'b1;
    converterClampN = 1'b1;
    adjOpen = 1'b1;
    analogCode = 10'h000;
    go = 1'b0;
    word = 10'h000;
    n_fail = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    conv(4);
    chk("gain reset", 32'h0000_0000, {24'h0, gainCode});
    chk("oe in standby", 32'h0000_0000, {31'h0, sampleOe});
    standbyN <= 1'b1;
    conv(4);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("clamp reg", 32'h0000_003E, rd);
    send({8'hA5, 2'h0});
    chk("gain", 32'h0000_00A5, {24'h0, gainCode});
    send({8'h07, 2'h1});
    chk("range", 32'h0000_0007, {29'h0, gainRangeSelect});
    chk("gain kept", 32'h0000_00A5, {24'h0, gainCode});
    send({8'h3F, 2'h2});
    chk("offset", 32'h0000_003F, {26'h0, blankOffset});
    send({8'h55, 2'h3});
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("settings", 32'h003F_07A5, rd);
    // straight binary codes pass bit for bit
    foreach (codes[i]) begin
      analogCode <= codes[i];
      conv(5);
      chk("sample", {22'h0, codes[i]}, {22'h0, sampleOut});
    end
    chk("oe run", 32'h0000_0001, {31'h0, sampleOe});
    blankN <= 1'b0;
    conv(5);
    chk("blank", 32'h0000_007D, {22'h0, sampleOut});
    converterClampN <= 1'b0;
    conv(5);
    chk("clamp open", 32'h0000_003E, {22'h0, sampleOut});
    apb(1'b1, 12'h000, 32'h0000_03F0);
    adjOpen <= 1'b0;
    conv(5);
    chk("clamp adj", 32'h0000_03F0, {22'h0, sampleOut});
    converterClampN <= 1'b1;
    conv(5);
    chk("blank sat", 32'h0000_03FF, {22'h0, sampleOut});
    blankN <= 1'b1;
    standbyN <= 1'b0;
    conv(5);
    chk("oe standby", 32'h0000_0000, {31'h0, sampleOe});
    send({8'h11, 2'h0});
    chk("gain standby", 32'h0000_00A5, {24'h0, gainCode});
    standbyN <= 1'b1;
    conv(5);
    chk("oe back", 32'h0000_0001, {31'h0, sampleOe});
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    // last running frame stays in the shift word; standby froze it
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("shift word", 32'h0001_0157, rd);
    report_and_stop();
  end
endmodule
